// >>> rtl/alias_match.v
// combinational compare of one incoming address against one alias entry
`include "alias_remap_map.vh"
module alias_match (
  // alias entry and incoming address
  input wire [6:0] i_alias,
  input wire [6:0] i_addr,
  // result
  output wire o_hit
);
  // zero alias never hits
  assign o_hit = (i_alias != `ALIAS_OFF) && (i_alias == i_addr);
endmodule // alias_match

// >>> rtl/alias_remap_map.vh
// register offsets, field layout and reset values of the alias remap block
// What this block does
// - target entries hold 7-bit address in bits 7..1, bit 0 reads zero
// - stored target address is the one driven on the far-side bus
// - address matching alias N is replaced by target entry N before forwarding
// - alias entries hold 7-bit address in bits 7..1, compared with incoming address
// - alias entry 1 pairs with target entry 1
// - alias field of zero disables matching for its entry
`ifndef ALIAS_REMAP_MAP_VH
`define ALIAS_REMAP_MAP_VH
`define OFS_TARGET_5 8'h74
`define OFS_TARGET_6 8'h75
`define OFS_TARGET_7 8'h76
`define OFS_ALIAS_1 8'h77
`define OFS_TARGET_1 8'h70
`define OFS_ALIAS_5 8'h7b
`define OFS_ALIAS_6 8'h7c
`define OFS_ALIAS_7 8'h7d
`define ADDR_MSB 7
`define ADDR_LSB 1
`define ADDR_W 7
`define REG_RESET 7'h00
`define ALIAS_OFF 7'h00
`define ZERO_BIT 1'b0
`define NO_SEL 2'h0
`define SEL_E1 2'h0
`define SEL_E5 2'h1
`define SEL_E6 2'h2
`define SEL_E7 2'h3
`define RDATA_IDLE 8'h00
`define NUM_ENTRIES 4
`define NO_HIT 4'h0
`define HIT_E1 0
`define HIT_E5 1
`define HIT_E6 2
`define HIT_E7 3
`define REG_SEL_W 8
`define RSEL_NONE 8'h00
`define RSEL_TGT_1 0
`define RSEL_TGT_5 1
`define RSEL_TGT_6 2
`define RSEL_TGT_7 3
`define RSEL_ALI_1 4
`define RSEL_ALI_5 5
`define RSEL_ALI_6 6
`define RSEL_ALI_7 7
`endif

// >>> rtl/remote_i2c_alias_remap.v
// alias to physical address translation with its register file
`include "alias_remap_map.vh"
module remote_i2c_alias_remap (
  // clock and reset
  input wire i_mclk,
  input wire i_srst,
  // register port
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // incoming transaction address
  input wire [6:0] i_tgt_addr,
  input wire i_tgt_valid,
  // forwarded transaction address
  output reg [6:0] o_fwd_addr,
  output reg o_fwd_valid,
  output reg o_fwd_drop
);
  // stored fields; bit 0 of each register has no storage behind it
  reg [6:0] remote_target_addr_field_1_reg;
  reg [6:0] remote_target_addr_field_5_reg;
  reg [6:0] remote_target_addr_field_6_reg;
  reg [6:0] remote_target_addr_field_7_reg;
  reg [6:0] local_match_addr_field_1_reg;
  reg [6:0] local_match_addr_field_5_reg;
  reg [6:0] local_match_addr_field_6_reg;
  reg [6:0] local_match_addr_field_7_reg;
  // next values of the registered outputs
  reg [7:0] rdata_next;
  reg [6:0] fwd_addr_next;
  reg fwd_valid_next;
  reg fwd_drop_next;
  // decoded register selects and alias hits
  wire [`REG_SEL_W-1:0] reg_sel;
  wire [`REG_SEL_W-1:0] wr_sel;
  wire [`REG_SEL_W-1:0] rd_sel;
  wire [`NUM_ENTRIES-1:0] hit;
  wire any_hit;
  wire [1:0] entry_sel;

  // register byte as software sees it: field in 7..1, reserved bit 0 low
  function [7:0] pack;
    input [6:0] f;
    begin
      pack = {f, `ZERO_BIT};
    end
  endfunction

  // field carried by a written byte; bit 0 is dropped, it is read-only
  function [6:0] field_of;
    input [7:0] d;
    begin
      field_of = d[`ADDR_MSB:`ADDR_LSB];
    end
  endfunction

  // one-hot select of the addressed register, all zero when unmapped
  function [`REG_SEL_W-1:0] reg_select;
    input [7:0] a;
    begin
      reg_select = `RSEL_NONE;
      case (a)
        `OFS_TARGET_1: reg_select[`RSEL_TGT_1] = 1'b1;
        `OFS_TARGET_5: reg_select[`RSEL_TGT_5] = 1'b1;
        `OFS_TARGET_6: reg_select[`RSEL_TGT_6] = 1'b1;
        `OFS_TARGET_7: reg_select[`RSEL_TGT_7] = 1'b1;
        `OFS_ALIAS_1: reg_select[`RSEL_ALI_1] = 1'b1;
        `OFS_ALIAS_5: reg_select[`RSEL_ALI_5] = 1'b1;
        `OFS_ALIAS_6: reg_select[`RSEL_ALI_6] = 1'b1;
        `OFS_ALIAS_7: reg_select[`RSEL_ALI_7] = 1'b1;
        default: reg_select = `RSEL_NONE;
      endcase
    end
  endfunction

  // winning entry; entry 1 first, then 5, 6, 7 when aliases repeat
  function [1:0] pick_entry;
    input [`NUM_ENTRIES-1:0] h;
    begin
      if (h[`HIT_E1])
        pick_entry = `SEL_E1;
      else if (h[`HIT_E5])
        pick_entry = `SEL_E5;
      else if (h[`HIT_E6])
        pick_entry = `SEL_E6;
      else if (h[`HIT_E7])
        pick_entry = `SEL_E7;
      else
        pick_entry = `NO_SEL;
    end
  endfunction

  assign reg_sel = reg_select(i_addr);
  // the master never raises both strobes, so one decode serves both
  assign wr_sel = i_wr ? reg_sel : `RSEL_NONE;
  assign rd_sel = i_rd ? reg_sel : `RSEL_NONE;

  // target entries: physical address driven on the far-side bus
  always @(posedge i_mclk) begin
    if (i_srst) begin
      remote_target_addr_field_1_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_TGT_1]) begin
      remote_target_addr_field_1_reg <= field_of(i_wdata);
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      remote_target_addr_field_5_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_TGT_5]) begin
      remote_target_addr_field_5_reg <= field_of(i_wdata);
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      remote_target_addr_field_6_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_TGT_6]) begin
      remote_target_addr_field_6_reg <= field_of(i_wdata);
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      remote_target_addr_field_7_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_TGT_7]) begin
      remote_target_addr_field_7_reg <= field_of(i_wdata);
    end
  end

  // alias entries: addresses the local decoder answers to
  always @(posedge i_mclk) begin
    if (i_srst) begin
      local_match_addr_field_1_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_ALI_1]) begin
      local_match_addr_field_1_reg <= field_of(i_wdata);
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      local_match_addr_field_5_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_ALI_5]) begin
      local_match_addr_field_5_reg <= field_of(i_wdata);
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      local_match_addr_field_6_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_ALI_6]) begin
      local_match_addr_field_6_reg <= field_of(i_wdata);
    end
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      local_match_addr_field_7_reg <= `REG_RESET;
    end else if (wr_sel[`RSEL_ALI_7]) begin
      local_match_addr_field_7_reg <= field_of(i_wdata);
    end
  end

  // read data stands one cycle after the strobe and is zero otherwise
  always @* begin
    rdata_next = `RDATA_IDLE;
    if (rd_sel[`RSEL_TGT_1])
      rdata_next = pack(remote_target_addr_field_1_reg);
    if (rd_sel[`RSEL_TGT_5])
      rdata_next = pack(remote_target_addr_field_5_reg);
    if (rd_sel[`RSEL_TGT_6])
      rdata_next = pack(remote_target_addr_field_6_reg);
    if (rd_sel[`RSEL_TGT_7])
      rdata_next = pack(remote_target_addr_field_7_reg);
    if (rd_sel[`RSEL_ALI_1])
      rdata_next = pack(local_match_addr_field_1_reg);
    if (rd_sel[`RSEL_ALI_5])
      rdata_next = pack(local_match_addr_field_5_reg);
    if (rd_sel[`RSEL_ALI_6])
      rdata_next = pack(local_match_addr_field_6_reg);
    if (rd_sel[`RSEL_ALI_7])
      rdata_next = pack(local_match_addr_field_7_reg);
  end

  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_rdata <= `RDATA_IDLE;
    end else begin
      o_rdata <= rdata_next;
    end
  end

  // one comparator per alias; a zero alias never hits
  alias_match u_m1 (
    .i_alias(local_match_addr_field_1_reg),
    .i_addr(i_tgt_addr),
    .o_hit(hit[`HIT_E1])
  );

  alias_match u_m5 (
    .i_alias(local_match_addr_field_5_reg),
    .i_addr(i_tgt_addr),
    .o_hit(hit[`HIT_E5])
  );

  alias_match u_m6 (
    .i_alias(local_match_addr_field_6_reg),
    .i_addr(i_tgt_addr),
    .o_hit(hit[`HIT_E6])
  );

  alias_match u_m7 (
    .i_alias(local_match_addr_field_7_reg),
    .i_addr(i_tgt_addr),
    .o_hit(hit[`HIT_E7])
  );

  assign any_hit = (hit != `NO_HIT);
  assign entry_sel = pick_entry(hit);

  // physical address of the winning entry, zero when nothing matched
  always @* begin
    fwd_valid_next = i_tgt_valid && any_hit;
    fwd_drop_next = i_tgt_valid && !any_hit;
    fwd_addr_next = `REG_RESET;
    if (any_hit) begin
      case (entry_sel)
        `SEL_E1: fwd_addr_next = remote_target_addr_field_1_reg;
        `SEL_E5: fwd_addr_next = remote_target_addr_field_5_reg;
        `SEL_E6: fwd_addr_next = remote_target_addr_field_6_reg;
        `SEL_E7: fwd_addr_next = remote_target_addr_field_7_reg;
        default: fwd_addr_next = `REG_RESET;
      endcase
    end
  end

  // outputs come straight from flip-flops, one cycle after the request
  always @(posedge i_mclk) begin
    if (i_srst) begin
      o_fwd_addr <= `REG_RESET;
      o_fwd_valid <= 1'b0;
      o_fwd_drop <= 1'b0;
    end else begin
      o_fwd_addr <= fwd_addr_next;
      o_fwd_valid <= fwd_valid_next;
      o_fwd_drop <= fwd_drop_next;
    end
  end
endmodule // remote_i2c_alias_remap

// >>> tb/alias_remap_monitor.sv
// port assertions for the alias remap block
module alias_remap_monitor(input wire i_mclk, i_srst, i_rd, i_tgt_valid,
  o_fwd_valid, o_fwd_drop, input wire [7:0] o_rdata, input wire [6:0] i_tgt_addr, o_fwd_addr);
  timeunit 1ns; timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  chk_one_answer: assert property (i_tgt_valid |=> o_fwd_valid ^ o_fwd_drop)
    else $error("no single answer");
  chk_idle_quiet: assert property (!i_tgt_valid |=> !o_fwd_valid && !o_fwd_drop)
    else $error("answer without request");
  chk_zero_drop: assert property (i_tgt_valid && i_tgt_addr == 7'h00 |=> o_fwd_drop)
    else $error("zero address matched");
  chk_drop_addr: assert property (o_fwd_drop |-> o_fwd_addr == 7'h00)
    else $error("address on drop");
  chk_rd_bit0: assert property (i_rd |=> !o_rdata[0])
    else $error("reserved bit set");
  chk_rd_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside slot");
  cover property (o_fwd_valid);
  cover property (o_fwd_drop);
  cover property (i_rd ##1 o_rdata != 8'h00);
endmodule // alias_remap_monitor
bind remote_i2c_alias_remap alias_remap_monitor mon(.*);

// >>> tb/far_side_target.sv
// far-side bus model: keeps the last address forwarded to it
module far_side_target(input wire clk, input wire valid, input wire [6:0] addr,
  output logic [6:0] seen);
  timeunit 1ns; timeprecision 1ns;
  initial seen = 7'h7f;
  // samples mid-cycle, as the wire would after launch
  always @(negedge clk) if (valid) seen <= addr;
endmodule // far_side_target

// >>> tb/remote_i2c_alias_remap_tb.sv
// bench: register access and address translation sequences
module remote_i2c_alias_remap_tb;
  timeunit 1ns; timeprecision 1ns;
  logic i_mclk = 0, i_srst = 1, i_wr = 0, i_rd = 0, i_tgt_valid = 0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00;
  logic [6:0] i_tgt_addr = 7'h00;
  logic [6:0] far_last = 7'h7f;
  wire [7:0] o_rdata;
  wire [6:0] o_fwd_addr, seen;
  wire o_fwd_valid, o_fwd_drop;
  int num_errors = 0, num_checks = 0, n = 0;
  remote_i2c_alias_remap uut(.*);
  far_side_target far(.clk(i_mclk), .valid(o_fwd_valid), .addr(o_fwd_addr), .seen(seen));
  initial forever #2 i_mclk = ~i_mclk;
  // ceiling far above the fewer than a hundred cycles the sequence needs
  always @(posedge i_mclk) begin
    n = n + 1;
    if (n > 999) begin
      num_errors++;
      print_verdict;
    end
  end
  task cmp_rdata(input [7:0] g, e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t read %h exp %h", $time, g, e);
    end
  endtask
  task cmp_fwd(input [8:0] g, e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t forward %h exp %h", $time, g, e);
    end
  endtask
  task cmp_far(input [6:0] g, e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t far side %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, d);
    @(posedge i_mclk) {i_addr, i_wdata, i_wr} <= {a, d, 1'b1};
    @(posedge i_mclk) i_wr <= 1'b0;
  endtask
  task rd(input [7:0] a, e);
    @(posedge i_mclk) {i_addr, i_rd} <= {a, 1'b1};
    @(posedge i_mclk) i_rd <= 1'b0;
    #1 cmp_rdata(o_rdata, e);
  endtask
  task xl(input [6:0] a, input v, input [6:0] e);
    @(posedge i_mclk) {i_tgt_addr, i_tgt_valid} <= {a, 1'b1};
    @(posedge i_mclk) i_tgt_valid <= 1'b0;
    #1 cmp_fwd({o_fwd_valid, o_fwd_drop, o_fwd_addr}, {v, !v, e});
    if (v) far_last = e;
    // a dropped address must leave the far side untouched
    #2 cmp_far(seen, far_last);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_mclk);
    i_srst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(8'h74 + i, 8'h00);
    wr(8'h77, 8'ha1);
    wr(8'h70, 8'h35);
    rd(8'h77, 8'ha0);
    rd(8'h70, 8'h34);
    xl(7'h50, 1, 7'h1a);
    // odd write data proves the reserved bit is dropped
    for (int i = 0; i < 3; i++) begin
      wr(8'h7b + i, 8'h80 + 2 * i);
      wr(8'h74 + i, 8'h21 + 2 * i);
      rd(8'h7b + i, 8'h80 + 2 * i);
      rd(8'h74 + i, 8'h20 + 2 * i);
      xl(7'h40 + i, 1, 7'h10 + i);
    end
    // unmapped writes are ignored and unmapped reads return zero
    wr(8'h73, 8'hff);
    rd(8'h73, 8'h00);
    xl(7'h33, 0, 7'h00);
    xl(7'h00, 0, 7'h00);
    wr(8'h77, 8'h00);
    xl(7'h50, 0, 7'h00);
    // only the reserved bit set leaves the alias at zero, so disabled
    wr(8'h7b, 8'h01);
    rd(8'h7b, 8'h00);
    xl(7'h40, 0, 7'h00);
    // a repeated alias goes to the lower entry
    wr(8'h7d, 8'h82);
    xl(7'h41, 1, 7'h11);
    // a second reset clears every entry
    @(posedge i_mclk) i_srst <= 1'b1;
    @(posedge i_mclk) i_srst <= 1'b0;
    rd(8'h75, 8'h00);
    rd(8'h7c, 8'h00);
    xl(7'h41, 0, 7'h00);
    print_verdict;
  end
endmodule // remote_i2c_alias_remap_tb
